// file: hw/ispr_consts.vh
// constants of the instrument status reporting block
//
// Contract
// - spoll bit 0 set while acquisition idle
// - spoll bit 1 set while command idle
// - spoll bit 2 is masked error summary
// - spoll bit 3 is masked measurement summary
// - spoll bit 4 set while output buffer nonempty
// - spoll bit 5 is masked standard event summary
// - spoll bit 6 on service request, 7 zero
// - meas bits 0-2 reserve, filter, output overload
// - meas bit 3 on reference lock lost
// - meas bit 4 on 200 Hz crossing
// - meas bit 5 on time constant change
// - meas bit 6 on any trigger
// - meas bit 7 when plot finishes
// - std bits 0, 2 queue overflows; 1, 3 unused
// - std bit 4 on execution error
// - std bit 5 on illegal command
// - std bit 6 user request, 7 power-on
// - error bits 0, 1, 3 print, backup, disk
// - error bits 2, 4 memory test faults
// - error bit 5 on aborted bus transfer
// - error bits 6, 7 processor, arithmetic faults
// - measurement mask writable whole or per bit
// - error mask writable whole or per bit
// - clear status command clears the measurement, standard event and error bytes
// - query returns whole byte or one bit
`ifndef ISPR_CONSTS_VH
`define ISPR_CONSTS_VH
// command opcodes
`define ISPR_OP_QUERY 2'h0
`define ISPR_OP_WRITE 2'h1
`define ISPR_OP_CLEAR 2'h2
`define ISPR_OP_SPOLL 2'h3
// byte selectors
`define ISPR_SEL_SPOLL 3'h0
`define ISPR_SEL_MEAS 3'h1
`define ISPR_SEL_STD 3'h2
`define ISPR_SEL_ERR 3'h3
`define ISPR_SEL_MEAS_EN 3'h4
`define ISPR_SEL_ERR_EN 3'h5
`define ISPR_SEL_STD_EN 3'h6
`define ISPR_SEL_SRQ_EN 3'h7
// serial poll bit positions
`define ISPR_SP_ACQ_IDLE 0
`define ISPR_SP_CMD_IDLE 1
`define ISPR_SP_ERR 2
`define ISPR_SP_MEAS 3
`define ISPR_SP_MAV 4
`define ISPR_SP_ESB 5
`define ISPR_SP_SRQ 6
`define ISPR_SP_UNUSED 7
// standard event bit positions
`define ISPR_SE_IN_OVF 0
`define ISPR_SE_OUT_OVF 2
`define ISPR_SE_EXEC_ERR 4
`define ISPR_SE_CMD 5
`define ISPR_SE_USER 6
`define ISPR_SE_POWER_ON 7
// measurement byte bit positions
`define ISPR_MC_RESERVE 0
`define ISPR_MC_FILTER 1
`define ISPR_MC_OUTPUT 2
`define ISPR_MC_UNLOCK 3
`define ISPR_MC_RANGE 4
`define ISPR_MC_TCONST 5
`define ISPR_MC_TRIGGERED 6
`define ISPR_MC_PLOT 7
// error byte bit positions
`define ISPR_ER_PRINT 0
`define ISPR_ER_BACKUP 1
`define ISPR_ER_RAM 2
`define ISPR_ER_DISK 3
`define ISPR_ER_ROM 4
`define ISPR_ER_BUS 5
`define ISPR_ER_DSP 6
`define ISPR_ER_MATH 7
// reset values and the service request source mask
`define ISPR_RST_FLAGS 8'h00
`define ISPR_RST_STD 8'h80
`define ISPR_RST_MASK 8'h00
`define ISPR_SRQ_SRC_MASK 8'h3f
`endif

// file: hw/ispr_status.v
// status bytes, enable masks, summaries and service request
`timescale 1ns/1ns
`include "ispr_consts.vh"
module ispr_status (
  input wire core_clk_in,
  input wire rst_n_in,
  // host command port
  input wire cmd_valid_in,
  input wire [1:0] cmd_op_in,
  input wire [2:0] cmd_sel_in,
  input wire cmd_bit_mode_in,
  input wire [2:0] cmd_bit_in,
  input wire [7:0] cmd_data_in,
  output reg rsp_valid_out,
  output reg [7:0] rsp_data_out,
  // instrument state, levels
  input wire acquisition_busy_in,
  input wire command_busy_in,
  input wire out_buf_nonempty_in,
  // measurement events, pulses
  input wire reserve_overload_in,
  input wire filter_overload_in,
  input wire output_overload_in,
  input wire reference_lock_lost_in,
  input wire freq_range_cross_in,
  input wire time_constant_changed_in,
  input wire hw_trigger_in,
  input wire sw_trigger_in,
  input wire plot_done_in,
  // standard events, pulses
  input wire input_queue_overflow_in,
  input wire output_queue_overflow_in,
  input wire execution_error_in,
  input wire illegal_command_in,
  input wire user_request_in,
  // error events, pulses
  input wire print_plot_fail_in,
  input wire backup_fail_in,
  input wire ram_test_fail_in,
  input wire disk_error_in,
  input wire rom_test_fail_in,
  input wire bus_transfer_abort_in,
  input wire dsp_test_fail_in,
  input wire math_error_in,
  // outputs
  output reg [7:0] serial_poll_out,
  output reg srq_out
);

  // whole byte, or selected bit in bit 0
  function [7:0] pick;
    input [7:0] b;
    input bm;
    input [2:0] idx;
    begin
      if (bm) begin
        pick = {7'h00, b[idx]};
      end else begin
        pick = b;
      end
    end
  endfunction

  // whole write or single-bit write of a mask
  function [7:0] wr_mask;
    input [7:0] old;
    input bm;
    input [2:0] idx;
    input [7:0] d;
    reg [7:0] t;
    begin
      t = old;
      if (bm) begin
        t[idx] = d[0];
      end else begin
        t = d;
      end
      wr_mask = t;
    end
  endfunction

  // masked summary of a status byte
  function any_set;
    input [7:0] b;
    input [7:0] en;
    begin
      any_set = |(b & en);
    end
  endfunction

  // all ones when a read-clear names this byte
  function [7:0] clr_mask;
    input hit;
    input [2:0] sel;
    input [2:0] want;
    begin
      if (hit && (sel == want)) begin
        clr_mask = 8'hff;
      end else begin
        clr_mask = 8'h00;
      end
    end
  endfunction

  reg [7:0] meas_r, meas_nxt;
  reg [7:0] std_r, std_nxt;
  reg [7:0] err_r, err_nxt;
  reg [7:0] meas_en_r, meas_en_nxt;
  reg [7:0] err_en_r, err_en_nxt;
  reg [7:0] std_en_r, std_en_nxt;
  reg [7:0] srq_en_r, srq_en_nxt;
  reg srq_flag_r, srq_flag_nxt;
  reg srq_src_r;
  reg [7:0] sp_now;
  reg [7:0] rd_byte;
  reg [7:0] meas_set, std_set, err_set;
  reg [7:0] meas_clr, std_clr, err_clr;
  reg srq_src;
  reg [7:0] rsp_data_nxt;
  wire take = cmd_valid_in;
  wire is_clear = take && (cmd_op_in == `ISPR_OP_CLEAR);
  wire is_query = take && (cmd_op_in == `ISPR_OP_QUERY);
  wire is_write = take && (cmd_op_in == `ISPR_OP_WRITE);
  wire is_spoll = take && (cmd_op_in == `ISPR_OP_SPOLL);
  // a whole-byte query of the measurement, standard event or error byte empties it; bit queries do not
  wire rd_clr = is_query && !cmd_bit_mode_in;

  always @* begin
    meas_set = 8'h00;
    meas_set[`ISPR_MC_RESERVE] = reserve_overload_in;
    meas_set[`ISPR_MC_FILTER] = filter_overload_in;
    meas_set[`ISPR_MC_OUTPUT] = output_overload_in;
    meas_set[`ISPR_MC_UNLOCK] = reference_lock_lost_in;
    meas_set[`ISPR_MC_RANGE] = freq_range_cross_in;
    meas_set[`ISPR_MC_TCONST] = time_constant_changed_in;
    // either trigger source lands on the same bit
    meas_set[`ISPR_MC_TRIGGERED] = hw_trigger_in | sw_trigger_in;
    meas_set[`ISPR_MC_PLOT] = plot_done_in;
    std_set = 8'h00;
    std_set[`ISPR_SE_IN_OVF] = input_queue_overflow_in;
    std_set[`ISPR_SE_OUT_OVF] = output_queue_overflow_in;
    std_set[`ISPR_SE_EXEC_ERR] = execution_error_in;
    std_set[`ISPR_SE_CMD] = illegal_command_in;
    std_set[`ISPR_SE_USER] = user_request_in;
    // fault pulses, sticky until a whole-byte read or clear status
    err_set = 8'h00;
    err_set[`ISPR_ER_PRINT] = print_plot_fail_in;
    err_set[`ISPR_ER_BACKUP] = backup_fail_in;
    err_set[`ISPR_ER_RAM] = ram_test_fail_in;
    err_set[`ISPR_ER_DISK] = disk_error_in;
    err_set[`ISPR_ER_ROM] = rom_test_fail_in;
    err_set[`ISPR_ER_BUS] = bus_transfer_abort_in;
    err_set[`ISPR_ER_DSP] = dsp_test_fail_in;
    err_set[`ISPR_ER_MATH] = math_error_in;
    meas_clr = clr_mask(rd_clr, cmd_sel_in, `ISPR_SEL_MEAS);
    std_clr = clr_mask(rd_clr, cmd_sel_in, `ISPR_SEL_STD);
    err_clr = clr_mask(rd_clr, cmd_sel_in, `ISPR_SEL_ERR);
    // clear status overrides the per-byte read clear
    if (is_clear) begin
      meas_clr = 8'hff;
      std_clr = 8'hff;
      err_clr = 8'hff;
    end
    // an event in the clearing cycle survives the clear
    meas_nxt = (meas_r & ~meas_clr) | meas_set;
    std_nxt = (std_r & ~std_clr) | std_set;
    err_nxt = (err_r & ~err_clr) | err_set;
  end

  always @* begin
    sp_now = 8'h00;
    // levels are copied live, never latched
    sp_now[`ISPR_SP_ACQ_IDLE] = !acquisition_busy_in;
    sp_now[`ISPR_SP_CMD_IDLE] = !command_busy_in;
    sp_now[`ISPR_SP_ERR] = any_set(err_r, err_en_r);
    sp_now[`ISPR_SP_MEAS] = any_set(meas_r, meas_en_r);
    sp_now[`ISPR_SP_MAV] = out_buf_nonempty_in;
    sp_now[`ISPR_SP_ESB] = any_set(std_r, std_en_r);
    sp_now[`ISPR_SP_SRQ] = srq_flag_r;
    sp_now[`ISPR_SP_UNUSED] = 1'b0;
    // service request fires only when enabled serial poll bits 0-5 go from none set to at least one set
    srq_src = |(sp_now & srq_en_r & `ISPR_SRQ_SRC_MASK);
    srq_flag_nxt = srq_flag_r;
    if (is_clear || is_spoll) begin
      srq_flag_nxt = 1'b0;
    end
    if (srq_src && !srq_src_r) begin
      srq_flag_nxt = 1'b1;
    end
  end

  always @* begin
    meas_en_nxt = meas_en_r;
    err_en_nxt = err_en_r;
    std_en_nxt = std_en_r;
    srq_en_nxt = srq_en_r;
    if (is_write) begin
      case (cmd_sel_in)
        `ISPR_SEL_MEAS_EN: begin
          meas_en_nxt = wr_mask(meas_en_r, cmd_bit_mode_in,
            cmd_bit_in, cmd_data_in);
        end
        `ISPR_SEL_ERR_EN: begin
          err_en_nxt = wr_mask(err_en_r, cmd_bit_mode_in,
            cmd_bit_in, cmd_data_in);
        end
        `ISPR_SEL_STD_EN: begin
          std_en_nxt = wr_mask(std_en_r, cmd_bit_mode_in,
            cmd_bit_in, cmd_data_in);
        end
        `ISPR_SEL_SRQ_EN: begin
          srq_en_nxt = wr_mask(srq_en_r, cmd_bit_mode_in,
            cmd_bit_in, cmd_data_in);
        end
        default: begin
          meas_en_nxt = meas_en_r;
        end
      endcase
    end
  end

  always @* begin
    case (cmd_sel_in)
      `ISPR_SEL_SPOLL: rd_byte = sp_now;
      `ISPR_SEL_MEAS: rd_byte = meas_r;
      `ISPR_SEL_STD: rd_byte = std_r;
      `ISPR_SEL_ERR: rd_byte = err_r;
      `ISPR_SEL_MEAS_EN: rd_byte = meas_en_r;
      `ISPR_SEL_ERR_EN: rd_byte = err_en_r;
      `ISPR_SEL_STD_EN: rd_byte = std_en_r;
      `ISPR_SEL_SRQ_EN: rd_byte = srq_en_r;
      default: rd_byte = 8'h00;
    endcase
  end

  // answer byte; holds the last answer between commands
  always @* begin
    rsp_data_nxt = rsp_data_out;
    if (is_spoll) begin
      rsp_data_nxt = sp_now;
    end else if (is_query) begin
      rsp_data_nxt = pick(rd_byte, cmd_bit_mode_in, cmd_bit_in);
    end
  end

  // event bytes; power-on bit comes up set
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      meas_r <= `ISPR_RST_FLAGS;
      std_r <= `ISPR_RST_STD;
      err_r <= `ISPR_RST_FLAGS;
    end else begin
      meas_r <= meas_nxt;
      std_r <= std_nxt;
      err_r <= err_nxt;
    end
  end

  // enable masks
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      meas_en_r <= `ISPR_RST_MASK;
      err_en_r <= `ISPR_RST_MASK;
      std_en_r <= `ISPR_RST_MASK;
      srq_en_r <= `ISPR_RST_MASK;
    end else begin
      meas_en_r <= meas_en_nxt;
      err_en_r <= err_en_nxt;
      std_en_r <= std_en_nxt;
      srq_en_r <= srq_en_nxt;
    end
  end

  // service request flag and its source edge
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      srq_flag_r <= 1'b0;
      srq_src_r <= 1'b0;
      srq_out <= 1'b0;
    end else begin
      srq_flag_r <= srq_flag_nxt;
      srq_src_r <= srq_src;
      // same value as the flag, kept as its own flop for the pin
      srq_out <= srq_flag_nxt;
    end
  end

  // host answers and the polled byte
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 8'h00;
      serial_poll_out <= 8'h00;
    end else begin
      rsp_valid_out <= is_query || is_spoll;
      rsp_data_out <= rsp_data_nxt;
      // bit 7 held at zero through the constant summary layout
      serial_poll_out <= sp_now;
    end
  end

endmodule

// file: verification/ispr_host.sv
// host controller model on the command port
`timescale 1ns/1ns
module ispr_host (
  input wire core_clk_in,
  output reg cmd_valid_in,
  output reg [1:0] cmd_op_in,
  output reg [2:0] cmd_sel_in,
  output reg cmd_bit_mode_in,
  output reg [2:0] cmd_bit_in,
  output reg [7:0] cmd_data_in,
  input wire [7:0] rsp_data_out
);
  initial begin
    {cmd_valid_in, cmd_op_in, cmd_sel_in, cmd_bit_mode_in} = 7'h00;
    {cmd_bit_in, cmd_data_in} = 11'h000;
  end
  // entered at a rising edge; answer read one edge after the taking edge
  task send(input [1:0] op, input [2:0] sel, input bm, input [2:0] bi,
    input [7:0] d, output [7:0] r);
    begin
      cmd_valid_in <= 1'b1;
      {cmd_op_in, cmd_sel_in} <= {op, sel};
      {cmd_bit_mode_in, cmd_bit_in} <= {bm, bi};
      cmd_data_in <= d;
      @(posedge core_clk_in);
      cmd_valid_in <= 1'b0;
      // stale data would hide a late sample
      cmd_data_in <= ~d;
      @(posedge core_clk_in);
      r = rsp_data_out;
    end
  endtask
endmodule

// file: verification/ispr_status_props.sv
// assertions on the status reporting block ports
`timescale 1ns/1ns
module ispr_status_props (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire cmd_valid_in,
  input wire [1:0] cmd_op_in,
  input wire cmd_bit_mode_in,
  input wire rsp_valid_out,
  input wire [7:0] rsp_data_out,
  input wire acquisition_busy_in,
  input wire command_busy_in,
  input wire out_buf_nonempty_in,
  input wire [7:0] serial_poll_out,
  input wire srq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // query and serial poll share equal opcode bits
  sequence s_ask;
    cmd_valid_in && (cmd_op_in[0] == cmd_op_in[1]);
  endsequence
  // past value is meaningless on the first edge out of reset
  sequence s_up;
    rst_n_in && $past(rst_n_in);
  endsequence
  a_acq_idle: assert property (s_up |->
    serial_poll_out[0] == !$past(acquisition_busy_in)) else $error("acq");
  a_cmd_idle: assert property (s_up |->
    serial_poll_out[1] == !$past(command_busy_in)) else $error("cmd");
  a_buf_nonempty: assert property (s_up |->
    serial_poll_out[4] == $past(out_buf_nonempty_in)) else $error("mav");
  a_srq_follow: assert property (s_up |->
    serial_poll_out[6] == $past(srq_out)) else $error("srq bit");
  a_top_unused: assert property (serial_poll_out[7] == 1'b0)
    else $error("bit 7 set");
  a_answer_time: assert property (s_ask |=> rsp_valid_out)
    else $error("no answer");
  a_answer_cause: assert property (rsp_valid_out |->
    $past(cmd_valid_in && cmd_op_in[0] == cmd_op_in[1]))
    else $error("stray answer");
  a_bit_answer: assert property (s_ask ##0 cmd_bit_mode_in |=>
    rsp_data_out[7:1] == 7'h00) else $error("bit answer wide");
endmodule
bind ispr_status ispr_status_props u_props (.*);

// file: verification/tb_ispr_status.sv
// testbench of the status reporting block
`timescale 1ns/1ns
`include "ispr_consts.vh"
module tb_ispr_status;
  reg core_clk_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg acquisition_busy_in = 1'b0;
  reg command_busy_in = 1'b0;
  reg out_buf_nonempty_in = 1'b0;
  reg [8:0] mv = 9'h000;
  reg [7:0] sv = 8'h00;
  reg [7:0] ev = 8'h00;
  reg [31:0] lfsr = 32'h414d;
  reg [7:0] r;
  reg [7:0] m;
  wire cmd_valid_in, cmd_bit_mode_in, rsp_valid_out, srq_out;
  wire [1:0] cmd_op_in;
  wire [2:0] cmd_sel_in, cmd_bit_in;
  wire [7:0] cmd_data_in, rsp_data_out, serial_poll_out;
  integer err_count = 0;
  integer total_checks = 0;
  integer i;
  always #25 core_clk_in = ~core_clk_in;
  ispr_host host (.*);
  ispr_status DUT (.*, .reserve_overload_in(mv[0]), .filter_overload_in(mv[1]),
    .output_overload_in(mv[2]), .reference_lock_lost_in(mv[3]),
    .freq_range_cross_in(mv[4]), .time_constant_changed_in(mv[5]),
    .hw_trigger_in(mv[6]), .plot_done_in(mv[7]), .sw_trigger_in(mv[8]),
    .input_queue_overflow_in(sv[0]), .output_queue_overflow_in(sv[2]),
    .execution_error_in(sv[4]), .illegal_command_in(sv[5]),
    .user_request_in(sv[6]), .print_plot_fail_in(ev[0]),
    .backup_fail_in(ev[1]), .ram_test_fail_in(ev[2]), .disk_error_in(ev[3]),
    .rom_test_fail_in(ev[4]), .bus_transfer_abort_in(ev[5]),
    .dsp_test_fail_in(ev[6]), .math_error_in(ev[7]));
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // software trigger lands on the hardware trigger bit
  function [7:0] ex(input [1:0] g, input [3:0] b);
    ex = 8'h01 << ((g == 2'h1 && b == 4'h8) ? 4'h6 : b);
  endfunction
  always @(posedge core_clk_in) begin
    lfsr <= nxt(lfsr);
    {acquisition_busy_in, command_busy_in, out_buf_nonempty_in} <= lfsr[2:0];
  end
  task check(input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // one event pulse, then a whole-byte read of its group
  task ev1(input [1:0] g, input [3:0] b, output [7:0] q);
    begin
      if (g == 2'h1) mv <= 9'h001 << b;
      else if (g == 2'h2) sv <= 8'h01 << b;
      else ev <= 8'h01 << b;
      @(posedge core_clk_in);
      {mv, sv, ev} <= 25'h0;
      host.send(`ISPR_OP_QUERY, {1'b0, g}, 1'b0, 3'h0, 8'h00, q);
    end
  endtask
  initial begin
    repeat (12) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    host.send(`ISPR_OP_QUERY, `ISPR_SEL_STD, 1'b0, 3'h0, 8'h00, r);
    check(r, 8'h80);
    host.send(`ISPR_OP_QUERY, `ISPR_SEL_STD, 1'b0, 3'h0, 8'h00, r);
    check(r, 8'h00);
    for (i = 0; i < 9; i = i + 1) begin
      ev1(2'h1, i[3:0], r);
      check(r, ex(2'h1, i[3:0]));
      ev1(2'h3, {1'b0, i[2:0]}, r);
      check(r, ex(2'h3, {1'b0, i[2:0]}));
      if ((8'h75 >> i) & 8'h01) begin
        ev1(2'h2, i[3:0], r);
        check(r, ex(2'h2, i[3:0]));
      end
    end
    host.send(`ISPR_OP_WRITE, `ISPR_SEL_SRQ_EN, 1'b0, 3'h0, 8'h0c, r);
    for (i = 0; i < 8; i = i + 1) begin
      m = lfsr[7:0];
      host.send(`ISPR_OP_WRITE, `ISPR_SEL_MEAS_EN, 1'b0, 3'h0, m, r);
      host.send(`ISPR_OP_WRITE, `ISPR_SEL_STD_EN, 1'b0, 3'h0, m, r);
      host.send(`ISPR_OP_WRITE, `ISPR_SEL_ERR_EN, 1'b0, 3'h0, ~m, r);
      host.send(`ISPR_OP_WRITE, `ISPR_SEL_ERR_EN, 1'b1, i[2:0], m >> i, r);
      mv <= 9'h001 << i;
      ev <= 8'h01 << i;
      sv <= 8'h40;
      @(posedge core_clk_in);
      {mv, sv, ev} <= 25'h0;
      @(posedge core_clk_in);
      #1;
      check({5'h0, serial_poll_out[5], serial_poll_out[3:2]},
        {5'h0, m[6], m[i], m[i]});
      repeat (2) @(posedge core_clk_in);
      #1;
      check({7'h0, srq_out}, {7'h0, m[i]});
      @(posedge core_clk_in);
      host.send(`ISPR_OP_SPOLL, 3'h0, 1'b0, 3'h0, 8'h00, r);
      check({r[6:5], r[3:2]}, {m[i], m[6], m[i], m[i]});
      check({7'h0, srq_out}, 8'h00);
      host.send(`ISPR_OP_QUERY, `ISPR_SEL_MEAS_EN, 1'b0, 3'h0, 8'h00, r);
      check(r, m);
      host.send(`ISPR_OP_QUERY, `ISPR_SEL_ERR_EN, 1'b1, i[2:0], 8'h00, r);
      check(r, {7'h0, m[i]});
      host.send(`ISPR_OP_QUERY, `ISPR_SEL_ERR, 1'b1, i[2:0], 8'h00, r);
      check(r, 8'h01);
      host.send(`ISPR_OP_CLEAR, 3'h0, 1'b0, 3'h0, 8'h00, r);
      host.send(`ISPR_OP_QUERY, `ISPR_SEL_MEAS, 1'b0, 3'h0, 8'h00, r);
      check(r, 8'h00);
      host.send(`ISPR_OP_QUERY, `ISPR_SEL_ERR, 1'b0, 3'h0, 8'h00, r);
      check(r, 8'h00);
    end
    finish_test;
  end
  initial begin
    #200000;
    err_count = err_count + 1;
    finish_test;
  end
endmodule
